// ### src/hsrp_port.sv
// Host serial register port with boundary-scan pin sharing
`timescale 1ns/1ps
`include "hsrp_map.svh"

module hsrp_port (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Shared pins
  input wire logic RESET_TRST_N,
  input wire logic TEST_SEL,
  input wire logic SCLK_TCK,
  input wire logic CS_N_TMS,
  input wire logic SER_IN_TDI,
  output logic SER_OUT_TDO,
  output logic SER_OUT_TDO_OE,
  // Boundary-scan controller side
  output logic SCAN_TCK,
  output logic SCAN_TMS,
  output logic SCAN_TDI,
  output logic SCAN_TRST_N,
  input wire logic SCAN_TDO,
  // Video core side
  input wire hsrp_pkg::hsrp_status_type STATUS,
  output hsrp_pkg::hsrp_config_type CONFIG,
  output logic OUTPUTS_HIZ
);

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic sclk_d;
  logic core_rst;
  logic rise;
  logic fall;
  logic cs_high;
  logic test_mode;
  logic din;
  hsrp_pkg::hsrp_state_type state;
  logic [`HSRP_CNT_W-1:0] cnt;
  logic [`HSRP_WORD_W-1:0] shift_in;
  logic [`HSRP_WORD_W-1:0] out_shift;
  logic [`HSRP_ADDR_W-1:0] cmd_addr;
  logic rd_loaded;
  logic wr_commit;
  logic [`HSRP_WORD_W-1:0] wr_data;
  logic [`HSRP_WORD_W-1:0] rd_word;
  logic [`HSRP_WORD_W-1:0] sticky;
  logic [`HSRP_WORD_W-1:0] next_sticky;
  logic [`HSRP_WORD_W-1:0] rw_mem [0:63];

  function automatic logic writable(input logic [`HSRP_ADDR_W-1:0] a);
    writable = (a == `HSRP_OFS_PROC_DISABLE) || (a == `HSRP_OFS_ERR_ENABLES) ||
      (a >= `HSRP_OFS_ANC_FIRST && a <= `HSRP_OFS_ANC_LAST) ||
      (a >= `HSRP_OFS_WINDOW_FIRST && a <= `HSRP_OFS_WINDOW_LAST);
  endfunction

  // Pin synchronisers: sclk, reset pin, cs, din, test select
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sync1 <= `HSRP_SYNC_IDLE;
      sync2 <= `HSRP_SYNC_IDLE;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= {TEST_SEL, SER_IN_TDI, CS_N_TMS, RESET_TRST_N, SCLK_TCK};
      sync2 <= sync1;
      sclk_d <= sync2[0];
    end
  end

  assign core_rst = SYS_RST | ~sync2[1];
  assign rise = sync2[0] & ~sclk_d;
  assign fall = ~sync2[0] & sclk_d;
  assign cs_high = sync2[2];
  assign din = sync2[3];
  assign test_mode = sync2[4];

  // Command and data sequencing
  always_ff @(posedge MCLK) begin
    if (core_rst || cs_high || test_mode) begin
      state <= hsrp_pkg::HSRP_IDLE;
      cnt <= '0;
      shift_in <= '0;
      cmd_addr <= '0;
      wr_commit <= 1'b0;
      wr_data <= '0;
    end else begin
      wr_commit <= 1'b0;
      unique case (state)
        hsrp_pkg::HSRP_IDLE: begin
          state <= hsrp_pkg::HSRP_CMD;
          cnt <= '0;
        end
        hsrp_pkg::HSRP_CMD: begin
          if (rise) begin
            shift_in <= {shift_in[14:0], din};
            cnt <= cnt + 1'b1;
            if (cnt == `HSRP_LAST_BIT) begin
              // Reserved bits dropped here
              cmd_addr <= {shift_in[`HSRP_CMD_ADDR_MSB-1:0], din};
              state <= shift_in[`HSRP_CMD_RW_BIT-1] ? hsrp_pkg::HSRP_RDATA :
                hsrp_pkg::HSRP_WDATA;
            end
          end
        end
        hsrp_pkg::HSRP_WDATA: begin
          if (rise) begin
            shift_in <= {shift_in[14:0], din};
            cnt <= cnt + 1'b1;
            if (cnt == `HSRP_LAST_BIT) begin
              wr_commit <= 1'b1;
              wr_data <= {shift_in[14:0], din};
              state <= hsrp_pkg::HSRP_DONE;
            end
          end
        end
        hsrp_pkg::HSRP_RDATA: begin
          if (rise) begin
            cnt <= cnt + 1'b1;
            if (cnt == `HSRP_LAST_BIT) begin
              state <= hsrp_pkg::HSRP_DONE;
            end
          end
        end
        hsrp_pkg::HSRP_DONE: begin
          state <= hsrp_pkg::HSRP_DONE;
        end
        default: begin
          state <= hsrp_pkg::HSRP_IDLE;
        end
      endcase
    end
  end

  // Read data shifter
  always_ff @(posedge MCLK) begin
    if (core_rst || cs_high || test_mode) begin
      out_shift <= '0;
      rd_loaded <= 1'b0;
    end else if (state == hsrp_pkg::HSRP_RDATA && fall) begin
      out_shift <= rd_loaded ? {out_shift[14:0], 1'b0} : rd_word;
      rd_loaded <= 1'b1;
    end
  end

  // Read map
  always_comb begin
    rd_word = '0;
    if (writable(cmd_addr)) begin
      rd_word = rw_mem[cmd_addr];
    end else if (cmd_addr == `HSRP_OFS_ERROR_FLAGS) begin
      rd_word = STATUS.error_flags;
    end else if (cmd_addr == `HSRP_OFS_CHECKWORD_FLAGS) begin
      rd_word = sticky;
    end else if (cmd_addr == `HSRP_OFS_STANDARD) begin
      rd_word = {9'h000, STATUS.interlaced, STATUS.standard_locked,
        STATUS.standard_code};
    end else if (cmd_addr >= `HSRP_OFS_PAYLOAD_FIRST && cmd_addr <= `HSRP_OFS_PAYLOAD_LAST) begin
      rd_word = STATUS.payload_id[cmd_addr[0]];
    end else if (cmd_addr >= `HSRP_OFS_RASTER_FIRST && cmd_addr <= `HSRP_OFS_RASTER_LAST) begin
      rd_word = STATUS.raster_counts[2'(cmd_addr - `HSRP_OFS_RASTER_FIRST)];
    end
  end

  // Writable registers
  always_ff @(posedge MCLK) begin
    if (core_rst) begin
      for (int i = 0; i < 64; i++) begin
        rw_mem[i] <= `HSRP_RESET_WORD;
      end
    end else if (wr_commit && writable(cmd_addr)) begin
      rw_mem[cmd_addr] <= wr_data;
    end
  end

  // Checkword flags: write one to clear, new event wins
  always_comb begin
    next_sticky = sticky;
    if (wr_commit && cmd_addr == `HSRP_OFS_CHECKWORD_FLAGS) begin
      next_sticky = sticky & ~wr_data;
    end
    next_sticky = next_sticky | STATUS.checkword_set;
  end

  always_ff @(posedge MCLK) begin
    if (core_rst) begin
      sticky <= '0;
    end else begin
      sticky <= next_sticky;
    end
  end

  // Pin ownership and output release
  always_ff @(posedge MCLK) begin
    if (core_rst) begin
      SER_OUT_TDO <= 1'b0;
      SER_OUT_TDO_OE <= 1'b0;
      SCAN_TCK <= 1'b0;
      SCAN_TMS <= 1'b1;
      SCAN_TDI <= 1'b0;
    end else if (test_mode) begin
      SER_OUT_TDO <= SCAN_TDO;
      SER_OUT_TDO_OE <= 1'b1;
      SCAN_TCK <= sync2[0];
      SCAN_TMS <= sync2[2];
      SCAN_TDI <= din;
    end else begin
      SER_OUT_TDO <= out_shift[15];
      SER_OUT_TDO_OE <= rd_loaded & ~cs_high;
      SCAN_TCK <= 1'b0;
      SCAN_TMS <= 1'b1;
      SCAN_TDI <= 1'b0;
    end
  end

  assign SCAN_TRST_N = ~(test_mode & ~sync2[1]);
  assign OUTPUTS_HIZ = core_rst;

  always_comb begin
    CONFIG.proc_disable = rw_mem[`HSRP_OFS_PROC_DISABLE];
    CONFIG.err_enables = rw_mem[`HSRP_OFS_ERR_ENABLES];
    for (int i = 0; i < 5; i++) begin
      CONFIG.anc_match[i] = rw_mem[6'(`HSRP_OFS_ANC_FIRST + i)];
    end
    for (int i = 0; i < 8; i++) begin
      CONFIG.window_bounds[i] = rw_mem[6'(`HSRP_OFS_WINDOW_FIRST + i)];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (core_rst);

  a_sample_rise_only: assert property (
    (state == hsrp_pkg::HSRP_CMD || state == hsrp_pkg::HSRP_WDATA) && !rise && !cs_high
    && !test_mode |=> $stable(shift_in)) else $error("input shifted without rising edge");
  a_cmd_selects_dir: assert property (
    state == hsrp_pkg::HSRP_CMD && rise && cnt == `HSRP_LAST_BIT && !cs_high && !test_mode
    |=> state == ($past(shift_in[14]) ? hsrp_pkg::HSRP_RDATA : hsrp_pkg::HSRP_WDATA))
    else $error("command flag chose wrong direction");
  a_first_read_bit: assert property (
    state == hsrp_pkg::HSRP_RDATA && fall && !rd_loaded && !cs_high && !test_mode
    |=> out_shift == $past(rd_word) ##1 SER_OUT_TDO == $past(out_shift[15]))
    else $error("read MSB not presented after command");
  a_shift_on_fall: assert property (
    rd_loaded && !fall && !cs_high && !test_mode |=> $stable(out_shift))
    else $error("read data moved without falling edge");
  a_cs_abandons: assert property (
    cs_high && !test_mode |=> state == hsrp_pkg::HSRP_IDLE && !rd_loaded
    ##1 (!SER_OUT_TDO_OE || $past(test_mode)))
    else $error("chip select high did not abandon access");
  a_unmapped_zero: assert property (
    cmd_addr == 6'h02 || cmd_addr == 6'h0a || cmd_addr == 6'h0b
    || cmd_addr > `HSRP_OFS_ERR_ENABLES |-> rd_word == '0)
    else $error("unassigned address not zero");
  a_write_lands: assert property (
    wr_commit && writable(cmd_addr) |=> rw_mem[$past(cmd_addr)] == $past(wr_data))
    else $error("write did not reach its register");
  a_test_owns_pins: assert property (
    test_mode |=> state == hsrp_pkg::HSRP_IDLE && SER_OUT_TDO_OE)
    else $error("host port active in test mode");
  a_scan_gated: assert property (
    !test_mode |=> !SCAN_TCK && SCAN_TMS) else $error("scan pins live outside test mode");
  a_hiz_in_reset: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !sync2[1] |-> OUTPUTS_HIZ ##1 !SER_OUT_TDO_OE) else $error("outputs driven in reset");
  a_event_wins: assert property (
    STATUS.checkword_set != '0 |=> (sticky & $past(STATUS.checkword_set)) == $past(STATUS.checkword_set))
    else $error("flag event lost");

  c_read_done: cover property (rd_loaded ##[1:400] state == hsrp_pkg::HSRP_DONE);
  c_write_done: cover property (wr_commit && writable(cmd_addr));
  c_abandon: cover property (state == hsrp_pkg::HSRP_WDATA ##1 cs_high);
  c_test_mode: cover property (test_mode && SER_OUT_TDO_OE);

endmodule

// ### src/hsrp_map.svh
// Register offsets, command layout and field positions of the host serial port
`ifndef HSRP_MAP_SVH
`define HSRP_MAP_SVH

`define HSRP_WORD_W 16
`define HSRP_ADDR_W 6
`define HSRP_CNT_W 4
`define HSRP_LAST_BIT 4'hf
`define HSRP_CMD_RW_BIT 15
`define HSRP_CMD_ADDR_MSB 5

`define HSRP_OFS_PROC_DISABLE 6'h00
`define HSRP_OFS_ERROR_FLAGS 6'h01
`define HSRP_OFS_CHECKWORD_FLAGS 6'h03
`define HSRP_OFS_STANDARD 6'h04
`define HSRP_OFS_ANC_FIRST 6'h05
`define HSRP_OFS_ANC_LAST 6'h09
`define HSRP_OFS_PAYLOAD_FIRST 6'h0c
`define HSRP_OFS_PAYLOAD_LAST 6'h0d
`define HSRP_OFS_RASTER_FIRST 6'h0e
`define HSRP_OFS_RASTER_LAST 6'h11
`define HSRP_OFS_WINDOW_FIRST 6'h12
`define HSRP_OFS_WINDOW_LAST 6'h19
`define HSRP_OFS_ERR_ENABLES 6'h1a

`define HSRP_RESET_WORD 16'h0000
// Synchroniser idle: reset pin and chip select high, burst clock low
`define HSRP_SYNC_IDLE 5'h06

`endif

// ### src/hsrp_pkg.sv
// Types shared by the host serial register port
package hsrp_pkg;

  typedef enum logic [2:0] {
    HSRP_IDLE = 3'b000,
    HSRP_CMD = 3'b001,
    HSRP_WDATA = 3'b010,
    HSRP_RDATA = 3'b011,
    HSRP_DONE = 3'b100
  } hsrp_state_type;

  // Status words supplied by the video core
  typedef struct packed {
    logic [15:0] error_flags;
    logic [15:0] checkword_set;
    logic [4:0] standard_code;
    logic standard_locked;
    logic interlaced;
    logic [1:0][15:0] payload_id;
    logic [3:0][15:0] raster_counts;
  } hsrp_status_type;

  // Configuration words driven to the video core
  typedef struct packed {
    logic [15:0] proc_disable;
    logic [4:0][15:0] anc_match;
    logic [7:0][15:0] window_bounds;
    logic [15:0] err_enables;
  } hsrp_config_type;

endpackage

// ### test/hsrp_host_model.sv
// Host processor model driving burst clock, chip select and serial input
`timescale 1ns/1ps

module hsrp_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Burst clock of 160 ns, idle low between frames; nb below 32 aborts early
  task automatic access(input logic rd, input logic [5:0] adr, input logic [15:0] wd,
      input int nb, output logic [15:0] rdat);
    logic [31:0] frame;
    frame = {rd, 9'h1ff, adr, wd};
    rdat = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    sdi <= frame[31];
    for (int i = 31; i >= 32 - nb; i--) begin
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      if (i < 16) rdat[i] = sdo;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      if (i > 0) sdi <= frame[i - 1];
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask

  task automatic pins(input logic tck, input logic tms, input logic tdi);
    @(posedge clk);
    sclk <= tck;
    cs_n <= tms;
    sdi <= tdi;
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the host serial register port
`timescale 1ns/1ps

module testbench;
  logic MCLK, SYS_RST, RESET_TRST_N, TEST_SEL, SCAN_TDO, sclk, cs_n, sdi;
  logic SER_OUT_TDO, SER_OUT_TDO_OE, SCAN_TCK, SCAN_TMS, SCAN_TDI, SCAN_TRST_N, OUTPUTS_HIZ;
  hsrp_pkg::hsrp_status_type STATUS;
  hsrp_pkg::hsrp_config_type CONFIG;
  wire sdo_line = SER_OUT_TDO_OE ? SER_OUT_TDO : 1'bz;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] rd;

  hsrp_port hsrp_port_i (.MCLK(MCLK), .SYS_RST(SYS_RST), .RESET_TRST_N(RESET_TRST_N),
    .TEST_SEL(TEST_SEL), .SCLK_TCK(sclk), .CS_N_TMS(cs_n), .SER_IN_TDI(sdi),
    .SER_OUT_TDO(SER_OUT_TDO), .SER_OUT_TDO_OE(SER_OUT_TDO_OE), .SCAN_TCK(SCAN_TCK),
    .SCAN_TMS(SCAN_TMS), .SCAN_TDI(SCAN_TDI), .SCAN_TRST_N(SCAN_TRST_N),
    .SCAN_TDO(SCAN_TDO), .STATUS(STATUS), .CONFIG(CONFIG), .OUTPUTS_HIZ(OUTPUTS_HIZ));

  hsrp_host_model hsrp_host_model_i (.clk(MCLK), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo_line));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    hsrp_host_model_i.access(1'b0, a, d, 32, rd);
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
    hsrp_host_model_i.access(1'b1, a, 16'h0000, 32, rd);
    check(rd, exp);
  endtask

  function automatic logic [15:0] expect_rd(input logic [5:0] a);
    case (a) inside
      6'h00, 6'h1a, [6'h05:6'h09], [6'h12:6'h19]: return 16'hc3a0 ^ 16'(a);
      6'h01: return 16'ha5c3;
      6'h04: return 16'h0035;
      6'h0c: return 16'h5678;
      6'h0d: return 16'h1234;
      6'h0e: return 16'h0438;
      6'h0f: return 16'h0780;
      6'h10: return 16'h0465;
      6'h11: return 16'h0898;
      default: return 16'h0000;
    endcase
  endfunction

  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    SYS_RST = 1'b1;
    RESET_TRST_N = 1'b1;
    TEST_SEL = 1'b0;
    SCAN_TDO = 1'b0;
    STATUS = '{error_flags: 16'ha5c3, checkword_set: 16'h0000, standard_code: 5'h15,
      standard_locked: 1'b1, interlaced: 1'b0, payload_id: {16'h1234, 16'h5678},
      raster_counts: {16'h0898, 16'h0465, 16'h0780, 16'h0438}};
    // Power-up hold shortened; design clears within two clocks
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (8) @(posedge MCLK);
    check(16'({OUTPUTS_HIZ, SER_OUT_TDO_OE}), 16'h0000);
    // Write addresses 0 to 32, then sweep reads; read-only and spare ones refuse writes
    for (int a = 0; a < 33; a++) wr(6'(a), 16'hc3a0 ^ 16'(a[5:0]));
    check(CONFIG.anc_match[4], 16'hc3a9);
    check(CONFIG.window_bounds[7], 16'hc3b9);
    for (int a = 0; a < 33; a++) rdchk(6'(a), expect_rd(6'(a)));
    rdchk(6'h3f, 16'h0000);
    @(posedge MCLK);
    STATUS.checkword_set <= 16'h0081;
    @(posedge MCLK);
    STATUS.checkword_set <= 16'h0000;
    rdchk(6'h03, 16'h0081);
    wr(6'h03, 16'h0001);
    rdchk(6'h03, 16'h0080);
    // Chip select rising mid-word and mid-command
    hsrp_host_model_i.access(1'b0, 6'h00, 16'h5555, 24, rd);
    hsrp_host_model_i.access(1'b0, 6'h1a, 16'h5555, 8, rd);
    check(16'(SER_OUT_TDO_OE), 16'h0000);
    check(CONFIG.proc_disable, 16'hc3a0);
    rdchk(6'h1a, 16'hc3ba);
    check(16'({SCAN_TCK, SCAN_TMS, SCAN_TDI}), 16'h0002);
    // Mid-run reset pulse, shortened like the power-up hold
    RESET_TRST_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    check(16'({OUTPUTS_HIZ, SER_OUT_TDO_OE}), 16'h0002);
    check(CONFIG.proc_disable, 16'h0000);
    RESET_TRST_N <= 1'b1;
    repeat (8) @(posedge MCLK);
    rdchk(6'h05, 16'h0000);
    // Shared pins handed to boundary scan
    TEST_SEL <= 1'b1;
    SCAN_TDO <= 1'b1;
    hsrp_host_model_i.pins(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge MCLK);
    check(16'({SCAN_TCK, SCAN_TMS, SCAN_TDI}), 16'h0005);
    check(16'({SER_OUT_TDO_OE, SER_OUT_TDO}), 16'h0003);
    RESET_TRST_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    check(16'(SCAN_TRST_N), 16'h0000);
    RESET_TRST_N <= 1'b1;
    TEST_SEL <= 1'b0;
    hsrp_host_model_i.pins(1'b1, 1'b1, 1'b1);
    repeat (6) @(posedge MCLK);
    check(16'({SCAN_TCK, SCAN_TMS, SCAN_TDI}), 16'h0002);
    results();
  end
endmodule
